/* File: core/dlp_regs.svh */
// Widths, depths and reset values of the DDR3 data lane pin block
`ifndef DLP_REGS_SVH
`define DLP_REGS_SVH
`define DLP_DQ_W 16
`define DLP_LANE_W 8
`define DLP_PAIR_W 32
`define DLP_FIFO_DEPTH 4
`define DLP_BEAT_RST 16'h0000
`define DLP_PAIR_RST 32'h0000_0000
`define DLP_EN_RST 4'h0
`endif

/* File: core/dlp_pkg.sv */
// Types shared by the DDR3 data lane pin block
`include "dlp_regs.svh"
package dlp_pkg;
  typedef logic [`DLP_DQ_W-1:0] dlp_beat_t;
  typedef logic [`DLP_PAIR_W-1:0] dlp_pair_t;
  typedef enum logic [1:0] {
    DLP_TX_IDLE = 2'b01,
    DLP_TX_WAIT = 2'b10
  } dlp_tx_e;
endpackage

/* File: core/dlp_lane.sv */
// DDR3 x16 data lane pins: read-path FIFO and the lane top module
// Overview of operation
// - The lower strobe times data bits 0-7 and the upper strobe times bits 8-15.
// - Each lane strobe is a differential pair, driven by us on reads, by the host on writes.
// - On reads the strobe edges coincide with the data transitions.
// - A write beat whose lane mask is high is dropped; lower mask bits 0-7, upper 8-15.
// - Data moves on both rising and falling strobe edges in both directions.
// - Termination control registered high turns on termination on data and strobes.
// - Termination control is ignored when both mode registers disable termination.
// - The reset pin is active low and asynchronous.
// - Masks act only on write beats, once per beat, each lane on its own.
`timescale 1ns/1ps
`include "dlp_regs.svh"
module dlp_fifo
  import dlp_pkg::*;
#(
  parameter int W = `DLP_PAIR_W,
  parameter int DEPTH = `DLP_FIFO_DEPTH
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic ce, // Clock enable
  input wire logic in_valid, // Write request
  input wire logic [W-1:0] in_data, // Write data
  output logic in_ready, // Room for a word
  output logic out_valid, // Word available
  output logic [W-1:0] out_data, // Head word
  input wire logic out_ready // Head taken
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic next_in_ready, push, pop;
  // Pointer and level bookkeeping
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    next_in_ready = next_count != (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
    end
  end
  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
endmodule // dlp_fifo

module dlp_lane_pins
  import dlp_pkg::*;
(
  input wire logic CLK_SYS, // System clock, 25 MHz
  input wire logic RST, // Async reset, high
  input wire logic CE, // System clock enable
  input wire logic LINK_CLK, // Link clock from host
  input wire logic RESET_N, // Device reset pin, low
  input wire logic [15:0] DQ_IN, // Data pins in
  output logic [15:0] DQ_OUT, // Data pins out
  output logic [15:0] DQ_OE, // Data pins drive
  input wire logic LOWER_BYTE_STROBE_IN, // Lower strobe in
  input wire logic LOWER_BYTE_STROBE_N_IN, // Lower strobe comp in
  output logic LOWER_BYTE_STROBE_OUT, // Lower strobe out
  output logic LOWER_BYTE_STROBE_N_OUT, // Lower comp out
  output logic LOWER_BYTE_STROBE_OE, // Lower strobe drive
  output logic LOWER_BYTE_STROBE_N_OE, // Lower comp drive
  input wire logic UPPER_BYTE_STROBE_IN, // Upper strobe in
  input wire logic UPPER_BYTE_STROBE_N_IN, // Upper strobe comp in
  output logic UPPER_BYTE_STROBE_OUT, // Upper strobe out
  output logic UPPER_BYTE_STROBE_N_OUT, // Upper comp out
  output logic UPPER_BYTE_STROBE_OE, // Upper strobe drive
  output logic UPPER_BYTE_STROBE_N_OE, // Upper comp drive
  input wire logic LOWER_BYTE_WRITE_MASK, // Lower lane mask
  input wire logic UPPER_BYTE_WRITE_MASK, // Upper lane mask
  input wire logic WR_WINDOW, // Write beats due, link
  input wire logic RD_WINDOW, // Read beats due, link
  input wire logic TERM_CTRL, // Termination control pin
  input wire logic MR1_RTT_OFF, // MR1 termination off
  input wire logic MR2_RTT_OFF, // MR2 termination off
  output logic TERM_EN, // Termination on
  input wire logic [31:0] RD_WORD, // Read pair to send
  input wire logic RD_VALID, // Read pair valid
  output logic RD_READY, // FIFO has room
  output logic [31:0] WR_WORD, // Received pair
  output logic [3:0] WR_BYTE_EN, // Kept bytes of pair
  output logic WR_VALID // Pair pulse
);
  logic rst_any;
  logic [1:0] masks, stbs, stb_ns;
  // Link rising edge state, except dq_n and next_keep_f from the falling edge
  logic win_r, next_win_r, term_en, next_term_en, load, take;
  logic [1:0] keep_r, next_keep_r, next_keep_f;
  dlp_beat_t beat_r, next_beat_r, dq_p, next_dq_p, fall_hold, next_fall_hold, dq_n;
  logic mr1_s1, mr1_s2, mr2_s1, mr2_s2, rq_s1, rq_s2;
  logic rq_seen, next_rq_seen, rd_full, next_rd_full, oe_q, tp, next_tp;
  dlp_pair_t rd_hold, next_rd_hold;
  // Link falling edge state
  logic tn, wr_tgl, next_wr_tgl;
  dlp_pair_t pair_hold, next_pair;
  logic [3:0] en_hold, next_en;
  // System side state
  dlp_tx_e state, next_state;
  dlp_pair_t tx_word, next_tx_word, f_data, next_wr_word;
  logic rd_req, next_rd_req, ak_s1, ak_s2, wt_s1, wt_s2, wt_s3;
  logic f_valid, f_ready, wr_new;

  // Lane takes a beat: window open, strobe pair at lvl, mask low
  function automatic logic [1:0] lane_keep(input logic win, input logic [1:0] m,
      input logic [1:0] s, input logic [1:0] sn, input logic lvl);
    lane_keep = {2{win}} & ~m & ~(s ^ {2{lvl}}) & (sn ^ {2{lvl}});
  endfunction

  // Byte mask from lane keep bits
  function automatic dlp_beat_t lane_bits(input logic [1:0] k);
    lane_bits = {{`DLP_LANE_W{k[1]}}, {`DLP_LANE_W{k[0]}}};
  endfunction

  assign rst_any = RST || !RESET_N;
  assign masks = {UPPER_BYTE_WRITE_MASK, LOWER_BYTE_WRITE_MASK};
  assign stbs = {UPPER_BYTE_STROBE_IN, LOWER_BYTE_STROBE_IN};
  assign stb_ns = {UPPER_BYTE_STROBE_N_IN, LOWER_BYTE_STROBE_N_IN};

  // Rising edge: rise beat capture, termination, read word hand-off
  always_comb begin
    next_win_r = WR_WINDOW;
    next_keep_r = lane_keep(WR_WINDOW, masks, stbs, stb_ns, 1'b1);
    next_beat_r = DQ_IN & lane_bits(next_keep_r);
    next_term_en = TERM_CTRL && !(mr1_s2 && mr2_s2);
    load = (rq_s2 != rq_seen) && !rd_full;
    take = RD_WINDOW && rd_full;
    next_rq_seen = load ? rq_s2 : rq_seen;
    next_rd_full = load || (rd_full && !take);
    next_rd_hold = load ? tx_word : rd_hold;
    next_dq_p = take ? rd_hold[15:0] : dq_p;
    next_fall_hold = take ? rd_hold[31:16] : fall_hold;
    next_tp = tp ^ RD_WINDOW;
  end

  always_ff @(posedge LINK_CLK or posedge rst_any) begin
    if (rst_any) begin
      win_r <= 1'b0;
      keep_r <= 2'b00;
      beat_r <= `DLP_BEAT_RST;
      term_en <= 1'b0;
      mr1_s1 <= 1'b0;
      mr1_s2 <= 1'b0;
      mr2_s1 <= 1'b0;
      mr2_s2 <= 1'b0;
      rq_s1 <= 1'b0;
      rq_s2 <= 1'b0;
      rq_seen <= 1'b0;
      rd_full <= 1'b0;
      rd_hold <= `DLP_PAIR_RST;
      dq_p <= `DLP_BEAT_RST;
      fall_hold <= `DLP_BEAT_RST;
      oe_q <= 1'b0;
      tp <= 1'b0;
    end else begin
      win_r <= next_win_r;
      keep_r <= next_keep_r;
      beat_r <= next_beat_r;
      term_en <= next_term_en;
      mr1_s1 <= MR1_RTT_OFF;
      mr1_s2 <= mr1_s1;
      mr2_s1 <= MR2_RTT_OFF;
      mr2_s2 <= mr2_s1;
      rq_s1 <= rd_req;
      rq_s2 <= rq_s1;
      rq_seen <= next_rq_seen;
      rd_full <= next_rd_full;
      rd_hold <= next_rd_hold;
      dq_p <= next_dq_p;
      fall_hold <= next_fall_hold;
      oe_q <= RD_WINDOW;
      tp <= next_tp;
    end
  end

  // Falling edge: fall beat capture and pair hand-off
  always_comb begin
    next_keep_f = lane_keep(win_r, masks, stbs, stb_ns, 1'b0);
    next_pair = win_r ? {DQ_IN & lane_bits(next_keep_f), beat_r} : pair_hold;
    next_en = win_r ? {next_keep_f, keep_r} : en_hold;
    next_wr_tgl = wr_tgl ^ win_r;
  end

  always_ff @(negedge LINK_CLK or posedge rst_any) begin
    if (rst_any) begin
      tn <= 1'b0;
      dq_n <= `DLP_BEAT_RST;
      pair_hold <= `DLP_PAIR_RST;
      en_hold <= `DLP_EN_RST;
      wr_tgl <= 1'b0;
    end else begin
      tn <= tp;
      dq_n <= fall_hold;
      pair_hold <= next_pair;
      en_hold <= next_en;
      wr_tgl <= next_wr_tgl;
    end
  end

  // Pin drive; strobe edges coincide with data edges on both clock edges
  assign DQ_OUT = (tp ^ tn) ? dq_p : dq_n;
  assign DQ_OE = {`DLP_DQ_W{oe_q}};
  assign LOWER_BYTE_STROBE_OUT = tp ^ tn;
  assign LOWER_BYTE_STROBE_N_OUT = ~(tp ^ tn);
  assign UPPER_BYTE_STROBE_OUT = tp ^ tn;
  assign UPPER_BYTE_STROBE_N_OUT = ~(tp ^ tn);
  assign LOWER_BYTE_STROBE_OE = oe_q;
  assign LOWER_BYTE_STROBE_N_OE = oe_q;
  assign UPPER_BYTE_STROBE_OE = oe_q;
  assign UPPER_BYTE_STROBE_N_OE = oe_q;
  assign TERM_EN = term_en;

  // Read pairs queue here until the link takes them
  dlp_fifo #(.W(`DLP_PAIR_W), .DEPTH(`DLP_FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst(rst_any),
    .ce(CE),
    .in_valid(RD_VALID),
    .in_data(RD_WORD),
    .in_ready(RD_READY),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_ready)
  );

  // System side: toggle handshake out, toggle detect in
  always_comb begin
    f_ready = (state == DLP_TX_IDLE);
    next_state = state;
    next_tx_word = tx_word;
    next_rd_req = rd_req;
    case (state)
      DLP_TX_IDLE: begin
        if (f_valid) begin
          next_tx_word = f_data;
          next_rd_req = ~rd_req;
          next_state = DLP_TX_WAIT;
        end
      end
      DLP_TX_WAIT: begin
        if (ak_s2 == rd_req) begin
          next_state = DLP_TX_IDLE;
        end
      end
      default: next_state = DLP_TX_IDLE;
    endcase
    wr_new = wt_s2 != wt_s3;
    next_wr_word = wr_new ? pair_hold : WR_WORD;
  end

  always_ff @(posedge CLK_SYS or posedge rst_any) begin
    if (rst_any) begin
      state <= DLP_TX_IDLE;
      tx_word <= `DLP_PAIR_RST;
      rd_req <= 1'b0;
      ak_s1 <= 1'b0;
      ak_s2 <= 1'b0;
      wt_s1 <= 1'b0;
      wt_s2 <= 1'b0;
      wt_s3 <= 1'b0;
      WR_WORD <= `DLP_PAIR_RST;
      WR_BYTE_EN <= `DLP_EN_RST;
      WR_VALID <= 1'b0;
    end else if (CE) begin
      state <= next_state;
      tx_word <= next_tx_word;
      rd_req <= next_rd_req;
      ak_s1 <= rq_seen;
      ak_s2 <= ak_s1;
      wt_s1 <= wr_tgl;
      wt_s2 <= wt_s1;
      wt_s3 <= wt_s2;
      WR_WORD <= next_wr_word;
      WR_BYTE_EN <= wr_new ? en_hold : WR_BYTE_EN;
      WR_VALID <= wr_new;
    end
  end

  chk_lane_strobe: assert property (@(posedge LINK_CLK) disable iff (rst_any)
    (WR_WINDOW && !LOWER_BYTE_STROBE_IN) |=> !keep_r[0])
    else $error("lower lane kept a beat without its strobe");
  chk_strobe_pair: assert property (@(posedge LINK_CLK) disable iff (rst_any)
    oe_q |-> (UPPER_BYTE_STROBE_OUT != UPPER_BYTE_STROBE_N_OUT) && UPPER_BYTE_STROBE_N_OE)
    else $error("strobe pair not differential");
  chk_strobe_rise: assert property (@(negedge LINK_CLK) disable iff (rst_any)
    oe_q |-> LOWER_BYTE_STROBE_OUT && !LOWER_BYTE_STROBE_N_OUT && DQ_OUT == dq_p)
    else $error("rise beat not aligned with strobe high");
  chk_upper_mask: assert property (@(posedge LINK_CLK) disable iff (rst_any)
    (WR_WINDOW && UPPER_BYTE_WRITE_MASK) |=> !keep_r[1] && beat_r[15:8] == 8'h00)
    else $error("masked upper beat kept");
  chk_byte_drop: assert property (@(posedge CLK_SYS) disable iff (rst_any)
    (WR_VALID && !WR_BYTE_EN[3]) |-> WR_WORD[31:24] == 8'h00)
    else $error("dropped byte not cleared");
  chk_fall_beat: assert property (@(posedge LINK_CLK) disable iff (rst_any)
    oe_q |-> !LOWER_BYTE_STROBE_OUT && DQ_OUT == dq_n)
    else $error("fall beat not driven after strobe fall");
  chk_term_on: assert property (@(posedge LINK_CLK) disable iff (rst_any)
    (TERM_CTRL && !(mr1_s2 && mr2_s2)) |=> TERM_EN)
    else $error("termination not enabled");
  chk_term_ignored: assert property (@(posedge LINK_CLK) disable iff (rst_any)
    (mr1_s2 && mr2_s2) |=> !TERM_EN)
    else $error("termination pin not ignored");
  chk_reset_pin: assert property (@(posedge CLK_SYS) disable iff (RST)
    !RESET_N |-> !WR_VALID && DQ_OE == 16'h0000 && !TERM_EN && state == DLP_TX_IDLE)
    else $error("reset pin low but state not reset");
  chk_mask_window: assert property (@(negedge LINK_CLK) disable iff (rst_any)
    !win_r |=> $stable(en_hold) && $stable(wr_tgl))
    else $error("mask acted outside a write");
  chk_fall_mask: assert property (@(negedge LINK_CLK) disable iff (rst_any)
    (win_r && !LOWER_BYTE_WRITE_MASK && !LOWER_BYTE_STROBE_IN && LOWER_BYTE_STROBE_N_IN)
    |=> en_hold[2] && pair_hold[23:16] == $past(DQ_IN[7:0]))
    else $error("fall beat lost with mask low");
endmodule // dlp_lane_pins

/* File: test/dlp_host_model.sv */
// Memory controller model facing the data lane pins
`timescale 1ns/1ps

module dlp_host_model (
  output logic LINK_CLK, // Link clock, runs only in frames
  output logic RESET_N, // Device reset pin
  output logic [15:0] DQ, // Host data drive
  output logic [3:0] STB, // Host strobes {lo, lo_n, up, up_n}
  output logic [1:0] MASK, // Lane masks {up, lo}
  output logic WR_WINDOW, // Write beats due
  output logic RD_WINDOW, // Read beats due
  input wire logic [15:0] DQ_PIN, // Resolved data pins
  input wire logic [3:0] STB_PIN // Resolved strobe pins
);
  logic run;
  // Link clock stands low between frames, phase unrelated to the system clock
  initial begin
    LINK_CLK = 1'b0;
    run = 1'b0;
    RESET_N = 1'b1;
    DQ = 16'h0000;
    STB = 4'b0101;
    MASK = 2'b00;
    WR_WINDOW = 1'b0;
    RD_WINDOW = 1'b0;
    #17;
    forever begin
      #62.5;
      if (run || LINK_CLK) LINK_CLK = ~LINK_CLK;
    end
  end
  // Runs the link for n cycles, stopping low
  task automatic idle(input int n);
    run = 1'b1;
    repeat (n) @(posedge LINK_CLK);
    @(negedge LINK_CLK);
    run = 1'b0;
    #10;
  endtask
  // Reset pin level, low only when a reset is meant
  task automatic set_reset(input logic v);
    RESET_N = v;
  endtask
  // One write pair; strobe levels change 10 ns after each edge
  task automatic write_pair(input logic [15:0] r, input logic [15:0] f, input logic [3:0] m);
    run = 1'b1;
    WR_WINDOW = 1'b1;
    DQ = r;
    MASK = m[1:0];
    STB = 4'b1010;
    @(posedge LINK_CLK);
    #10;
    DQ = f;
    MASK = m[3:2];
    STB = 4'b0101;
    @(negedge LINK_CLK);
    #10;
    WR_WINDOW = 1'b0;
    DQ = ~f;
    MASK = ~m[3:2];
    STB = 4'b1010;
  endtask
  // One read pair; host lines keep toggling so only device drive can match the data and the fall strobes
  task automatic read_pair(output logic [15:0] r, output logic [15:0] f,
                           output logic [3:0] sr, output logic [3:0] sf);
    run = 1'b1;
    RD_WINDOW = 1'b1;
    STB = 4'b0101;
    DQ = ~DQ;
    @(posedge LINK_CLK);
    #10;
    RD_WINDOW = 1'b0;
    STB = 4'b1010;
    DQ = ~DQ;
    #30;
    r = DQ_PIN;
    sr = STB_PIN;
    @(negedge LINK_CLK);
    #30;
    f = DQ_PIN;
    sf = STB_PIN;
  endtask
endmodule // dlp_host_model

/* File: test/dlp_lane_pins_bench.sv */
// Self-checking bench for the DDR3 x16 data lane pins
`timescale 1ns/1ps

module dlp_lane_pins_bench
  import dlp_pkg::*;
;
  logic CLK_SYS, RST, ce, rd_valid, rd_ready, wr_valid, term_ctrl, mr1, mr2, term_en;
  logic link_clk, reset_n, wr_win, rd_win;
  dlp_pair_t rd_word, wr_word;
  logic [3:0] wr_be, stb_out, stb_oe, h_stb;
  logic [15:0] dq_out, dq_oe, h_dq;
  logic [1:0] h_mask;
  wire logic [15:0] dq_pin;
  wire logic [3:0] stb_pin;
  int num_errors, tests_run, cyc;
  // Pin levels from the device enables; the host drives wherever the device does not
  assign dq_pin = (dq_oe & dq_out) | (~dq_oe & h_dq);
  assign stb_pin = (stb_oe & stb_out) | (~stb_oe & h_stb);
  dlp_host_model host (.LINK_CLK(link_clk), .RESET_N(reset_n), .DQ(h_dq), .STB(h_stb),
    .MASK(h_mask), .WR_WINDOW(wr_win), .RD_WINDOW(rd_win), .DQ_PIN(dq_pin), .STB_PIN(stb_pin));
  dlp_lane_pins dut (.CLK_SYS(CLK_SYS), .RST(RST), .CE(ce), .LINK_CLK(link_clk),
    .RESET_N(reset_n), .DQ_IN(dq_pin), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
    .LOWER_BYTE_STROBE_IN(stb_pin[3]), .LOWER_BYTE_STROBE_N_IN(stb_pin[2]),
    .LOWER_BYTE_STROBE_OUT(stb_out[3]), .LOWER_BYTE_STROBE_N_OUT(stb_out[2]),
    .LOWER_BYTE_STROBE_OE(stb_oe[3]), .LOWER_BYTE_STROBE_N_OE(stb_oe[2]),
    .UPPER_BYTE_STROBE_IN(stb_pin[1]), .UPPER_BYTE_STROBE_N_IN(stb_pin[0]),
    .UPPER_BYTE_STROBE_OUT(stb_out[1]), .UPPER_BYTE_STROBE_N_OUT(stb_out[0]),
    .UPPER_BYTE_STROBE_OE(stb_oe[1]), .UPPER_BYTE_STROBE_N_OE(stb_oe[0]),
    .LOWER_BYTE_WRITE_MASK(h_mask[0]), .UPPER_BYTE_WRITE_MASK(h_mask[1]),
    .WR_WINDOW(wr_win), .RD_WINDOW(rd_win), .TERM_CTRL(term_ctrl), .MR1_RTT_OFF(mr1),
    .MR2_RTT_OFF(mr2), .TERM_EN(term_en), .RD_WORD(rd_word), .RD_VALID(rd_valid),
    .RD_READY(rd_ready), .WR_WORD(wr_word), .WR_BYTE_EN(wr_be), .WR_VALID(wr_valid));
  // System clock, 40 ns
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  // Compares one value and counts it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
  // Every mask pattern over both lanes and both beats
  task automatic t_write();
    dlp_beat_t r, f;
    logic [3:0] m;
    logic [31:0] exp;
    int n;
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      r = {12'ha5c, m};
      f = {m, 12'h3c5};
      exp = {m[3] ? 8'h00 : f[15:8], m[2] ? 8'h00 : f[7:0],
             m[1] ? 8'h00 : r[15:8], m[0] ? 8'h00 : r[7:0]};
      host.write_pair(r, f, m);
      n = 0;
      while (wr_valid !== 1'b1 && n < 40) begin
        @(posedge CLK_SYS);
        #5;
        n++;
      end
      chk({31'h0, wr_valid}, 32'h1, "write pulse");
      chk(wr_word, exp, "write word");
      chk({28'h0, wr_be}, {28'h0, ~m}, "byte enables");
    end
    host.idle(2);
  endtask
  // Fill the buffer until refused, then drain it over the link
  task automatic t_read();
    dlp_pair_t q[$];
    dlp_beat_t r, f;
    logic [3:0] sr, sf;
    int n;
    n = 0;
    // Clock enable low: offered pushes must not land
    @(posedge CLK_SYS);
    #5;
    ce = 1'b0;
    rd_valid = 1'b1;
    rd_word = 32'hc0de_0001;
    repeat (6) begin
      @(posedge CLK_SYS);
      #5;
    end
    chk({31'h0, rd_ready}, 32'h1, "frozen by enable");
    rd_valid = 1'b0;
    ce = 1'b1;
    @(posedge CLK_SYS);
    #5;
    while (rd_ready === 1'b1 && n < 8) begin
      rd_word = 32'h5a5a_0f0f ^ {8{n[3:0]}};
      rd_valid = 1'b1;
      q.push_back(rd_word);
      @(posedge CLK_SYS);
      #5;
      n++;
    end
    rd_word = 32'hdead_beef;
    @(posedge CLK_SYS);
    #5;
    rd_valid = 1'b0;
    chk({31'h0, rd_ready}, 32'h0, "buffer full");
    foreach (q[k]) begin
      host.idle(4);
      host.read_pair(r, f, sr, sf);
      chk({f, r}, q[k], "read data");
      chk({24'h0, sr, sf}, 32'h0000_00a5, "read strobes");
    end
    host.idle(4);
    chk({31'h0, rd_ready}, 32'h1, "buffer drained");
  endtask
  // Termination control against both mode settings
  task automatic t_term();
    logic [2:0] s;
    for (int i = 0; i < 8; i++) begin
      s = i[2:0];
      term_ctrl = s[0];
      mr1 = s[1];
      mr2 = s[2];
      host.idle(4);
      chk({31'h0, term_en}, {31'h0, s[0] & ~(s[1] & s[2])}, "termination");
    end
  endtask
  // Reset pin with the link stopped and between system edges
  task automatic t_reset();
    term_ctrl = 1'b1;
    mr1 = 1'b0;
    host.idle(4);
    chk({31'h0, term_en}, 32'h1, "termination on");
    @(posedge CLK_SYS);
    #5;
    host.set_reset(1'b0);
    #5;
    chk({term_en, wr_valid, rd_ready, stb_out}, 32'h0000_0015, "reset outputs");
    chk({dq_oe, 12'h000, stb_oe}, 32'h0, "reset drive");
    host.idle(2);
    host.set_reset(1'b1);
    host.idle(4);
    chk({31'h0, term_en}, 32'h1, "after reset");
  endtask
  // Main sequence
  initial begin
    RST = 1'b1;
    ce = 1'b1;
    rd_valid = 1'b0;
    rd_word = 32'h0;
    term_ctrl = 1'b0;
    mr1 = 1'b0;
    mr2 = 1'b0;
    num_errors = 0;
    tests_run = 0;
    cyc = 0;
    repeat (10) @(posedge CLK_SYS);
    host.idle(2);
    @(posedge CLK_SYS);
    #5;
    RST = 1'b0;
    host.idle(3);
    t_write();
    t_read();
    t_term();
    t_reset();
    close_out();
  end
endmodule // dlp_lane_pins_bench
